// File: hw/mcuxt_pkg.sv
// shared constants and types of the instruction execute tail
`default_nettype none
package mcuxt_pkg;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_TAB_LO = 8'h0c;
    localparam logic [7:0] OFF_TAB_PAGE = 8'h10;
    localparam logic [7:0] OFF_TAB_HI = 8'h14;
    localparam logic [7:0] OFF_PC = 8'h18;
    localparam logic [7:0] OFF_MADDR = 8'h1c;
    localparam logic [7:0] OFF_MDATA = 8'h20;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BIT_LSB = 5;
    localparam int CMD_IMM_LSB = 8;
    localparam int CMD_ADDR_LSB = 16;
    localparam int ST_BUSY_BIT = 8;
    // ----------------------------------------
    // reset values and fixed figures
    // ----------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam logic [7:0] LAST_PAGE = 8'hff;
    localparam logic [7:0] DAA_LO = 8'h06;
    localparam logic [7:0] DAA_HI = 8'h60;
    localparam logic [3:0] BCD_MAX = 4'h9;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_NIB_ACC = 5'h01, OP_SKZ = 5'h02, OP_SKZ_ACC = 5'h03,
        OP_SKZ_BIT = 5'h04, OP_TRD_P = 5'h05, OP_TRD_L = 5'h06,
        OP_ITRD_P = 5'h07, OP_ITRD_L = 5'h08, OP_XOR_A = 5'h09,
        OP_XOR_M = 5'h0a, OP_XOR_I = 5'h0b, OP_ADC_A = 5'h0c, OP_ADC_M = 5'h0d,
        OP_ADD_A = 5'h0e, OP_ADD_M = 5'h0f, OP_AND_A = 5'h10, OP_AND_M = 5'h11,
        OP_CLR = 5'h12, OP_CLR_BIT = 5'h13, OP_CPL = 5'h14, OP_CPL_A = 5'h15,
        OP_DAA = 5'h16, OP_DEC = 5'h17, OP_DEC_A = 5'h18, OP_INC = 5'h19,
        OP_INC_A = 5'h1a, OP_MOV_A = 5'h1b, OP_MOV_M = 5'h1c, OP_OR_A = 5'h1d
    } mcuxt_op_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_DUMMY = 2'b10
    } mcuxt_state_e;
    typedef struct packed {
        logic sgn;
        logic wrap;
        logic z;
        logic half;
        logic c;
    } mcuxt_flags_s;
    typedef struct packed {
        logic [7:0] res;
        mcuxt_flags_s fl;
    } mcuxt_alu_s;
    typedef struct packed {
        mcuxt_state_e state;
        mcuxt_op_e op;
        logic [2:0] bitsel;
        logic [7:0] imm;
        logic [7:0] addr;
        logic [7:0] acc;
        mcuxt_flags_s fl;
        logic [7:0] tab_lo;
        logic [7:0] tab_page;
        logic [7:0] tab_hi;
        logic [15:0] pc;
        logic [15:0] prog_addr;
        logic [7:0] maddr;
        logic [31:0] prdata;
    } mcuxt_core_s;
endpackage
`default_nettype wire

// File: hw/mcuxt_core.sv
// instruction execute tail: datapath, sequencer and apb register slave
`default_nettype none
// What this block does
// RULE1: nibble exchange puts swapped memory nibbles in acc; memory, flags kept
// RULE2: skip_if_zero rewrites byte unchanged, skips when zero, flags kept
// RULE3: taken skip adds one dummy cycle; untaken continues normally
// RULE4: skip_zero_copy_acc loads byte into acc, skips when zero
// RULE5: bit test skips when selected bit is zero, flags kept
// RULE6: paged table read: word at page and low pointer, low to memory, high to latch
// RULE7: final-page read uses last page with low pointer only
// RULE8: incrementing paged read bumps low pointer first, then fetches
// RULE9: incrementing final-page read bumps low pointer first, then fetches
// RULE10: xor with memory to acc or memory, or with immediate to acc only, zero flag updated
// RULE11: far operations address any data memory byte directly, no banking
// RULE12: far add with carry to acc or memory, five arithmetic flags updated
// RULE13: far add without carry to acc or memory, five flags updated
// RULE14: far and to acc or memory, zero flag updated
// RULE15: far clear writes zero, bit clear zeroes one bit, flags kept
// RULE16: far complement to memory or acc only, zero flag updated
// RULE17: decimal adjust adds six per nibble on limit or carry, result to memory
// RULE18: decimal adjust changes only carry, set when sum passes ninety-nine
// RULE19: far decrement in place or into acc only, zero flag updated
// RULE20: far increment in place or into acc only, zero flag updated
// RULE21: far move copies memory to acc or acc to memory, flags kept
// RULE22: far or stores acc or memory into acc
// RULE23: unskipped instructions take one cycle and advance pc by one
module mcuxt_core #(
    parameter int DM_DEPTH = 256,
    parameter int PAW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [PAW-1:0] prog_addr,
    input wire logic [15:0] prog_rdata,
    output logic busy
);
    localparam int DM_AW = (DM_DEPTH > 1) ? $clog2(DM_DEPTH) : 1;

    if (DM_DEPTH < 2 || DM_DEPTH > 256 || (DM_DEPTH & (DM_DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("DM_DEPTH must be a power of two from 2 to 256");
    end
    if (PAW < 9 || PAW > 16)
    begin : g_bad_paw
        $error("PAW must lie between 9 and 16");
    end

    // ----------------------------------------
    // arithmetic helper
    // ----------------------------------------
    function automatic mcuxt_pkg::mcuxt_alu_s add8(input logic [7:0] a,
        input logic [7:0] b, input logic cin);
        logic [8:0] s;
        logic [4:0] h;
        mcuxt_pkg::mcuxt_alu_s o;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        o.res = s[7:0];
        o.fl.c = s[8];
        o.fl.half = h[4];
        o.fl.z = (s[7:0] == 8'h00);
        o.fl.wrap = (a[7] == b[7]) && (s[7] != a[7]);
        // sign of the true, unwrapped sum
        o.fl.sgn = o.fl.wrap ^ s[7];
        return o;
    endfunction

    function automatic logic [DM_AW-1:0] midx(input logic [7:0] a);
        return a[DM_AW-1:0];
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    mcuxt_pkg::mcuxt_core_s r_reg;
    mcuxt_pkg::mcuxt_core_s r_next;
    logic [7:0] mem_reg [DM_DEPTH];
    logic mem_we;
    logic [DM_AW-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic [7:0] m_val;
    logic [7:0] m_swap;
    logic take_skip;
    logic setup;
    logic wr_acc;
    logic mapped;
    logic [31:0] rd_mux;
    logic [7:0] tab_lo_new;

    assign m_val = mem_reg[midx(r_reg.addr)]; // RULE11
    assign m_swap = {m_val[3:0], m_val[7:4]};
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = r_reg.prdata;
    assign prog_addr = r_reg.prog_addr[PAW-1:0];
    assign busy = (r_reg.state != mcuxt_pkg::ST_IDLE);

    // ----------------------------------------
    // register read path
    // ----------------------------------------
    always_comb
    begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            mcuxt_pkg::OFF_CMD: rd_mux = {8'h00, r_reg.addr, r_reg.imm, r_reg.bitsel, r_reg.op};
            mcuxt_pkg::OFF_ACC: rd_mux = {24'h000000, r_reg.acc};
            mcuxt_pkg::OFF_STATUS:
            begin
                rd_mux[4:0] = r_reg.fl;
                rd_mux[mcuxt_pkg::ST_BUSY_BIT] = busy;
            end
            mcuxt_pkg::OFF_TAB_LO: rd_mux = {24'h000000, r_reg.tab_lo};
            mcuxt_pkg::OFF_TAB_PAGE: rd_mux = {24'h000000, r_reg.tab_page};
            mcuxt_pkg::OFF_TAB_HI: rd_mux = {24'h000000, r_reg.tab_hi};
            mcuxt_pkg::OFF_PC: rd_mux = {16'h0000, r_reg.pc};
            mcuxt_pkg::OFF_MADDR: rd_mux = {24'h000000, r_reg.maddr};
            mcuxt_pkg::OFF_MDATA: rd_mux = {24'h000000, mem_reg[midx(r_reg.maddr)]};
            default: mapped = 1'b0;
        endcase
    end

    // ----------------------------------------
    // next state: register writes and execution
    // ----------------------------------------
    always_comb
    begin
        mcuxt_pkg::mcuxt_alu_s al;
        logic [7:0] adj;
        logic [8:0] ds;
        logic [7:0] t;
        al = '0;
        adj = 8'h00;
        ds = 9'h000;
        t = 8'h00;
        r_next = r_reg;
        mem_we = 1'b0;
        mem_wa = midx(r_reg.addr);
        mem_wd = m_val;
        take_skip = 1'b0;
        tab_lo_new = r_reg.tab_lo;
        if (setup)
        begin
            r_next.prdata = rd_mux;
        end
        case (r_reg.state)
            mcuxt_pkg::ST_IDLE:
            begin
                // writes are refused while an instruction is in flight
                if (wr_acc)
                begin
                    case (paddr)
                        mcuxt_pkg::OFF_CMD:
                        begin
                            r_next.op = mcuxt_pkg::mcuxt_op_e'(pwdata[mcuxt_pkg::CMD_OP_LSB +: 5]);
                            r_next.bitsel = pwdata[mcuxt_pkg::CMD_BIT_LSB +: 3];
                            r_next.imm = pwdata[mcuxt_pkg::CMD_IMM_LSB +: 8];
                            r_next.addr = pwdata[mcuxt_pkg::CMD_ADDR_LSB +: 8];
                            r_next.state = mcuxt_pkg::ST_EXEC;
                            if (r_next.op == mcuxt_pkg::OP_ITRD_P ||
                                r_next.op == mcuxt_pkg::OP_ITRD_L)
                            begin
                                tab_lo_new = r_reg.tab_lo + 8'h01; // RULE8 RULE9
                            end
                            r_next.tab_lo = tab_lo_new;
                            // pointer fetch issued now so the word is ready in the exec cycle
                            if (r_next.op == mcuxt_pkg::OP_TRD_L ||
                                r_next.op == mcuxt_pkg::OP_ITRD_L)
                            begin
                                r_next.prog_addr = {mcuxt_pkg::LAST_PAGE, tab_lo_new}; // RULE7
                            end
                            else
                            begin
                                r_next.prog_addr = {r_reg.tab_page, tab_lo_new}; // RULE6
                            end
                        end
                        mcuxt_pkg::OFF_ACC: r_next.acc = pwdata[7:0];
                        mcuxt_pkg::OFF_STATUS: r_next.fl = pwdata[4:0];
                        mcuxt_pkg::OFF_TAB_LO: r_next.tab_lo = pwdata[7:0];
                        mcuxt_pkg::OFF_TAB_PAGE: r_next.tab_page = pwdata[7:0];
                        mcuxt_pkg::OFF_PC: r_next.pc = pwdata[15:0];
                        mcuxt_pkg::OFF_MADDR: r_next.maddr = pwdata[7:0];
                        mcuxt_pkg::OFF_MDATA:
                        begin
                            mem_we = 1'b1;
                            mem_wa = midx(r_reg.maddr);
                            mem_wd = pwdata[7:0];
                        end
                        default: r_next.state = r_reg.state;
                    endcase
                end
            end
            mcuxt_pkg::ST_EXEC:
            begin
                case (r_reg.op)
                    mcuxt_pkg::OP_NIB_ACC: r_next.acc = m_swap; // RULE1
                    mcuxt_pkg::OP_SKZ:
                    begin
                        mem_we = 1'b1; // RULE2
                        take_skip = (m_val == 8'h00); // RULE2
                    end
                    mcuxt_pkg::OP_SKZ_ACC:
                    begin
                        r_next.acc = m_val; // RULE4
                        take_skip = (m_val == 8'h00); // RULE4
                    end
                    mcuxt_pkg::OP_SKZ_BIT: take_skip = !m_val[r_reg.bitsel]; // RULE5
                    mcuxt_pkg::OP_TRD_P, mcuxt_pkg::OP_TRD_L,
                    mcuxt_pkg::OP_ITRD_P, mcuxt_pkg::OP_ITRD_L:
                    begin
                        mem_we = 1'b1; // RULE6 RULE7
                        mem_wd = prog_rdata[7:0];
                        r_next.tab_hi = prog_rdata[15:8];
                    end
                    mcuxt_pkg::OP_XOR_A, mcuxt_pkg::OP_XOR_M, mcuxt_pkg::OP_XOR_I,
                    mcuxt_pkg::OP_AND_A, mcuxt_pkg::OP_AND_M, mcuxt_pkg::OP_OR_A,
                    mcuxt_pkg::OP_CPL, mcuxt_pkg::OP_CPL_A, mcuxt_pkg::OP_DEC,
                    mcuxt_pkg::OP_DEC_A, mcuxt_pkg::OP_INC, mcuxt_pkg::OP_INC_A:
                    begin
                        case (r_reg.op)
                            mcuxt_pkg::OP_XOR_I: t = r_reg.acc ^ r_reg.imm; // RULE10
                            mcuxt_pkg::OP_XOR_A, mcuxt_pkg::OP_XOR_M: t = r_reg.acc ^ m_val; // RULE10
                            mcuxt_pkg::OP_AND_A, mcuxt_pkg::OP_AND_M: t = r_reg.acc & m_val; // RULE14
                            mcuxt_pkg::OP_OR_A: t = r_reg.acc | m_val; // RULE22
                            mcuxt_pkg::OP_CPL, mcuxt_pkg::OP_CPL_A: t = ~m_val; // RULE16
                            mcuxt_pkg::OP_DEC, mcuxt_pkg::OP_DEC_A: t = m_val - 8'h01; // RULE19
                            default: t = m_val + 8'h01; // RULE20
                        endcase
                        r_next.fl.z = (t == 8'h00);
                        if (r_reg.op == mcuxt_pkg::OP_XOR_M || r_reg.op == mcuxt_pkg::OP_AND_M ||
                            r_reg.op == mcuxt_pkg::OP_CPL || r_reg.op == mcuxt_pkg::OP_DEC ||
                            r_reg.op == mcuxt_pkg::OP_INC)
                        begin
                            mem_we = 1'b1;
                            mem_wd = t;
                        end
                        else
                        begin
                            r_next.acc = t;
                        end
                    end
                    mcuxt_pkg::OP_ADC_A, mcuxt_pkg::OP_ADC_M,
                    mcuxt_pkg::OP_ADD_A, mcuxt_pkg::OP_ADD_M:
                    begin
                        if (r_reg.op == mcuxt_pkg::OP_ADC_A || r_reg.op == mcuxt_pkg::OP_ADC_M)
                        begin
                            al = add8(r_reg.acc, m_val, r_reg.fl.c); // RULE12
                        end
                        else
                        begin
                            al = add8(r_reg.acc, m_val, 1'b0); // RULE13
                        end
                        r_next.fl = al.fl;
                        if (r_reg.op == mcuxt_pkg::OP_ADC_M || r_reg.op == mcuxt_pkg::OP_ADD_M)
                        begin
                            mem_we = 1'b1;
                            mem_wd = al.res;
                        end
                        else
                        begin
                            r_next.acc = al.res;
                        end
                    end
                    mcuxt_pkg::OP_CLR:
                    begin
                        mem_we = 1'b1;
                        mem_wd = mcuxt_pkg::RST_BYTE; // RULE15
                    end
                    mcuxt_pkg::OP_CLR_BIT:
                    begin
                        mem_we = 1'b1;
                        mem_wd = m_val & ~(8'h01 << r_reg.bitsel); // RULE15
                    end
                    mcuxt_pkg::OP_DAA:
                    begin
                        if (r_reg.acc[3:0] > mcuxt_pkg::BCD_MAX || r_reg.fl.half)
                        begin
                            adj = adj | mcuxt_pkg::DAA_LO; // RULE17
                        end
                        // high nibble judged after the low fix, else 9a would stay non-decimal
                        ds = {1'b0, r_reg.acc} + {1'b0, adj};
                        if (ds[7:4] > mcuxt_pkg::BCD_MAX || r_reg.fl.c || ds[8])
                        begin
                            adj = adj | mcuxt_pkg::DAA_HI; // RULE17
                        end
                        mem_we = 1'b1;
                        mem_wd = r_reg.acc + adj;
                        // only carry moves; it marks a decimal sum beyond 99
                        r_next.fl.c = r_reg.fl.c || adj[6] || ds[8]; // RULE18
                    end
                    mcuxt_pkg::OP_MOV_A: r_next.acc = m_val; // RULE21
                    mcuxt_pkg::OP_MOV_M:
                    begin
                        mem_we = 1'b1;
                        mem_wd = r_reg.acc; // RULE21
                    end
                    default: mem_we = 1'b0;
                endcase
                r_next.pc = r_reg.pc + 16'h0001; // RULE23
                r_next.state = take_skip ? mcuxt_pkg::ST_DUMMY : mcuxt_pkg::ST_IDLE; // RULE3
            end
            mcuxt_pkg::ST_DUMMY:
            begin
                // dummy cycle steps over the skipped word
                r_next.pc = r_reg.pc + 16'h0001; // RULE3
                r_next.state = mcuxt_pkg::ST_IDLE;
            end
            default: r_next.state = mcuxt_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_reg <= '0;
            r_reg.pc <= mcuxt_pkg::RST_PC;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < DM_DEPTH; i++)
            begin
                mem_reg[i] <= mcuxt_pkg::RST_BYTE;
            end
        end
        else if (mem_we)
        begin
            mem_reg[mem_wa] <= mem_wd;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_swap_nibbles: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        (r_reg.state == mcuxt_pkg::ST_EXEC && r_reg.op == mcuxt_pkg::OP_NIB_ACC)
        |=> (r_reg.acc == $past(m_swap)) && (r_reg.fl == $past(r_reg.fl)))
        else $error("nibble exchange result wrong");
    a_skip_dummy: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        (r_reg.state == mcuxt_pkg::ST_EXEC && take_skip)
        |=> r_reg.state == mcuxt_pkg::ST_DUMMY ##1 r_reg.state == mcuxt_pkg::ST_IDLE)
        else $error("taken skip not two cycles");
    a_single_cycle: assert property (@(posedge pclk) disable iff (!presetn) // RULE23
        (r_reg.state == mcuxt_pkg::ST_EXEC && !take_skip)
        |=> r_reg.state == mcuxt_pkg::ST_IDLE && r_reg.pc == $past(r_reg.pc) + 16'h0001)
        else $error("plain instruction not one cycle");
    a_zero_skip: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        (r_reg.state == mcuxt_pkg::ST_EXEC && r_reg.op == mcuxt_pkg::OP_SKZ)
        |-> (take_skip == (m_val == 8'h00)) ##1 (r_reg.fl == $past(r_reg.fl)))
        else $error("zero test skip wrong");
    a_bit_skip: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        (r_reg.state == mcuxt_pkg::ST_EXEC && r_reg.op == mcuxt_pkg::OP_SKZ_BIT &&
        ((m_val >> r_reg.bitsel) & 8'h01) == 8'h00)
        |=> r_reg.state == mcuxt_pkg::ST_DUMMY)
        else $error("bit test did not skip");
    a_ptr_bump: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        (r_reg.state == mcuxt_pkg::ST_IDLE && wr_acc && paddr == mcuxt_pkg::OFF_CMD &&
        pwdata[4:0] == 5'h07)
        |=> r_reg.tab_lo == $past(r_reg.tab_lo) + 8'h01 && r_reg.prog_addr[7:0] == r_reg.tab_lo)
        else $error("pointer not bumped before fetch");
    a_final_page: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        (r_reg.state == mcuxt_pkg::ST_IDLE && wr_acc && paddr == mcuxt_pkg::OFF_CMD &&
        pwdata[4:0] == 5'h06)
        |=> r_reg.prog_addr[15:8] == 8'hff)
        else $error("final page not selected");
    a_xor_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        (r_reg.state == mcuxt_pkg::ST_EXEC && r_reg.op == mcuxt_pkg::OP_XOR_A)
        |=> r_reg.fl.z == (r_reg.acc == 8'h00))
        else $error("xor zero flag wrong");
    a_daa_flags: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
        (r_reg.state == mcuxt_pkg::ST_EXEC && r_reg.op == mcuxt_pkg::OP_DAA)
        |=> r_reg.fl[4:1] == $past(r_reg.fl[4:1]) && r_reg.acc == $past(r_reg.acc))
        else $error("decimal adjust touched other flags");
endmodule
`default_nettype wire

// File: verification/mcuxt_core_tb.sv
// self-checking bench for the instruction execute tail
`default_nettype none
module mcuxt_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, psel, penable, pwrite, pready, pslverr, busy, se;
    logic presetn_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] prog_addr, prog_rdata;
    int err_count = 0;
    int check_count = 0;
    int bcnt = 0;
    // ----------------------------------------
    // clock, program rom, busy counter
    // ----------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    function automatic logic [15:0] rom(input logic [15:0] a);
        return {a[7:0] ^ 8'h3c, a[15:8] ^ a[7:0]};
    endfunction
    assign prog_rdata = rom(prog_addr);
    always @(posedge pclk)
        if (busy === 1'b1)
            bcnt++;
    mcuxt_core uut (.pclk(pclk), .presetn(presetn_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prog_addr(prog_addr), .prog_rdata(prog_rdata), .busy(busy));
    // ----------------------------------------
    // bus and checking tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        se = pslverr;
        if (n >= 20)
        begin
            err_count++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so the next setup never lands in the same time step
        @(posedge pclk);
    endtask
    // c: {addr, imm, bit, op}; v: {mem in, acc in, mem out, acc out}; f: {flags in, out}
    task automatic run(input logic [23:0] c, input logic [31:0] v, input logic [15:0] f,
        input int cyc);
        logic [15:0] pc0;
        apb(1'b1, mcuxt_pkg::OFF_MADDR, {24'h0, c[23:16]});
        apb(1'b1, mcuxt_pkg::OFF_MDATA, {24'h0, v[31:24]});
        apb(1'b1, mcuxt_pkg::OFF_ACC, {24'h0, v[23:16]});
        apb(1'b1, mcuxt_pkg::OFF_STATUS, {27'h0, f[12:8]});
        apb(1'b0, mcuxt_pkg::OFF_PC, 32'h0);
        pc0 = q[15:0];
        bcnt = 0;
        apb(1'b1, mcuxt_pkg::OFF_CMD, {8'h0, c});
        repeat (3) @(posedge pclk);
        chk("busy cycles", 32'(cyc), 32'(bcnt));
        apb(1'b0, mcuxt_pkg::OFF_PC, 32'h0);
        chk("pc", {16'h0, pc0 + 16'(cyc)}, q);
        apb(1'b0, mcuxt_pkg::OFF_MDATA, 32'h0);
        chk("mem", {24'h0, v[15:8]}, q);
        apb(1'b0, mcuxt_pkg::OFF_ACC, 32'h0);
        chk("acc", {24'h0, v[7:0]}, q);
        apb(1'b0, mcuxt_pkg::OFF_STATUS, 32'h0);
        chk("flags", {27'h0, f[4:0]}, q);
    endtask
    task automatic bus_checks();
        apb(1'b0, mcuxt_pkg::OFF_PC, 32'h0);
        chk("pc after reset", 32'h0, q);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, se});
    endtask
    task automatic skip_tests();
        run(24'h100001, 32'h3c003cc3, 16'h1515, 1);
        run(24'hff0002, 32'h00550055, 16'h0a0a, 2);
        run(24'hff0002, 32'h80558055, 16'h0a0a, 1);
        run(24'h200003, 32'h00770000, 16'h1f1f, 2);
        run(24'h300064, 32'hf700f700, 16'h1515, 2);
        run(24'h300064, 32'h08000800, 16'h1515, 1);
    endtask
    task automatic logic_tests();
        run(24'ha00009, 32'h5a5a5a00, 16'h0004, 1);
        run(24'ha1000a, 32'h0ff0fff0, 16'h0400, 1);
        run(24'ha2ff0b, 32'h120f12f0, 16'h0400, 1);
        run(24'hc10011, 32'hf00f000f, 16'h0004, 1);
        run(24'hc00010, 32'h3c0f3c0c, 16'h0000, 1);
        run(24'h000012, 32'ha5110011, 16'h1b1b, 1);
        run(24'hfe00f3, 32'hff117f11, 16'h0000, 1);
        run(24'h810014, 32'hff110011, 16'h0004, 1);
        run(24'h820015, 32'h0f110ff0, 16'h0400, 1);
        run(24'h83001b, 32'h00110000, 16'h0000, 1);
        run(24'h84001c, 32'h009c9c9c, 16'h0404, 1);
        run(24'h85001d, 32'h80018081, 16'h0400, 1);
    endtask
    task automatic arith_tests();
        run(24'h40000e, 32'h017f0180, 16'h000a, 1);
        run(24'h41000f, 32'h80800080, 16'h001d, 1);
        run(24'h42000c, 32'h010e0110, 16'h0102, 1);
        run(24'h43000d, 32'h00ff00ff, 16'h0107, 1);
        run(24'h440016, 32'h339a009a, 16'h0001, 1);
        run(24'h450016, 32'h33151b15, 16'h1e1e, 1);
        run(24'h460017, 32'h01000000, 16'h0004, 1);
        run(24'h470018, 32'h000000ff, 16'h0400, 1);
        run(24'h480019, 32'hff000000, 16'h0004, 1);
        run(24'h49001a, 32'h7f007f80, 16'h0400, 1);
    endtask
    task automatic table_reads();
        logic [7:0] p;
        logic [15:0] w;
        logic [15:0] a;
        for (int k = 5; k <= 8; k++)
        begin
            apb(1'b1, mcuxt_pkg::OFF_TAB_LO, 32'hff);
            apb(1'b1, mcuxt_pkg::OFF_TAB_PAGE, 32'h12);
            p = (k >= 7) ? 8'h00 : 8'hff;
            a = {(k == 6 || k == 8) ? mcuxt_pkg::LAST_PAGE : 8'h12, p};
            w = rom(a);
            run({16'he000, 8'(k)}, {16'h5a11, w[7:0], 8'h11}, 16'h1515, 1);
            chk("program address", {16'h0, a}, {16'h0, prog_addr});
            apb(1'b0, mcuxt_pkg::OFF_TAB_HI, 32'h0);
            chk("table high", {24'h0, w[15:8]}, q);
            apb(1'b0, mcuxt_pkg::OFF_TAB_LO, 32'h0);
            chk("table low", {24'h0, p}, q);
        end
    endtask
    initial
    begin
        presetn_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn_n <= 1'b1;
        @(posedge pclk);
        bus_checks();
        skip_tests();
        logic_tests();
        arith_tests();
        table_reads();
        finish_test();
    end
endmodule
`default_nettype wire
